// >>> pus_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module pus_assertions
	import pus_pkg::*;
#(
	parameter int unsigned STRAP_CYCLES = PUS_STRAP_CYCLES
) (
	input wire logic       mclk,
	input wire logic       reset,
	input wire pus_req_t   reg_req,
	input wire logic [7:0] reg_rdata,
	input wire pus_mclk_t  mclk_sel,
	input wire logic       strap_done,
	input wire logic       cfg_loaded,
	input wire logic [5:0] strap_value,
	input wire logic [7:0] ref_mode,
	input wire logic [7:0] diff_out_enable,
	input wire logic [3:0] se_out_enable
);
	int unsigned run_cnt;
	always_ff @(posedge mclk)
		run_cnt <= cfg_loaded ? 1 : run_cnt + 1;
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	sequence s_latch;
		$rose(strap_done);
	endsequence
	a_clk_select: assert property (s_latch |-> mclk_sel == (strap_value[1:0] == 2'b10 ?
		PUS_MCLK_20M : strap_value[1:0] == 2'b11 ? PUS_MCLK_24M576 : PUS_MCLK_RESERVED))
		else $error("clock select");
	a_strap_time: assert property (s_latch |-> run_cnt == STRAP_CYCLES)
		else $error("strap interval");
	a_strap_hold: assert property (strap_done && $past(strap_done) |->
		$stable(strap_value) && $stable(mclk_sel)) else $error("straps moved");
	a_ref_default: assert property (cfg_loaded |-> ref_mode == PUS_REF_MODE_RESET)
		else $error("ref default");
	a_outs_off: assert property (cfg_loaded |-> diff_out_enable == 8'h00 &&
		se_out_enable == 4'h0) else $error("outputs on");
	a_diff_strap: assert property (s_latch |-> diff_out_enable[0] == strap_value[2])
		else $error("diff strap");
	a_early_wr: assert property (!strap_done && reg_req.wr |=> se_out_enable == 4'h0)
		else $error("early write");
	a_ref_write: assert property (strap_done && reg_req.wr &&
		reg_req.addr == PUS_REF_MODE_ADDR |=> ref_mode == $past(reg_req.wdata))
		else $error("ref write");
	a_ref_read: assert property (reg_req.rd && reg_req.addr == PUS_REF_MODE_ADDR
		|=> reg_rdata == $past(ref_mode)) else $error("ref read");
endmodule // pus_assertions
bind pus_top pus_assertions #(.STRAP_CYCLES(STRAP_CYCLES)) chk_u (.mclk, .reset, .reg_req,
	.reg_rdata, .mclk_sel, .strap_done, .cfg_loaded, .strap_value, .ref_mode,
	.diff_out_enable, .se_out_enable);
`default_nettype wire

// >>> pus_board.sv
`timescale 1ns/100ps
`default_nettype none
module pus_board #(
	parameter int LOW_CYC  = 10,
	parameter int HOLD_CYC = 32
) (
	input  wire logic       mclk,
	input  wire logic       restart,
	input  wire logic [5:0] strap_cfg,
	output logic            power_reset_n,
	output logic      [5:0] gpio_pin
);
	int cnt = 0;
	always @(posedge mclk)
		cnt <= restart ? 0 : cnt + 1;
	assign power_reset_n = cnt >= LOW_CYC;
	// Released straps show the opposite level
	assign gpio_pin = cnt < LOW_CYC + HOLD_CYC ? strap_cfg : ~strap_cfg;
endmodule // pus_board
`default_nettype wire

// >>> pus_pkg.sv
package pus_pkg;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int unsigned PUS_CLK_HZ        = 50_000_000;
	localparam int unsigned PUS_STRAP_MS      = 55;
	localparam int unsigned PUS_STRAP_CYCLES  = PUS_STRAP_MS * (PUS_CLK_HZ / 1000);
	localparam int unsigned PUS_CNT_W         = 22;

	// ---------------------------------------------------------------
	// Register map
	// ---------------------------------------------------------------
	localparam logic [7:0] PUS_REF_MODE_ADDR  = 8'h0a;
	localparam logic [7:0] PUS_DIFF_EN_ADDR   = 8'h0b;
	localparam logic [7:0] PUS_SE_EN_ADDR     = 8'h0c;
	localparam logic [7:0] PUS_STATUS_ADDR    = 8'h0d;

	localparam logic [7:0] PUS_REF_MODE_RESET = 8'h01;
	localparam logic [7:0] PUS_DIFF_EN_RESET  = 8'h00;
	localparam logic [3:0] PUS_SE_EN_RESET    = 4'h0;

	// ---------------------------------------------------------------
	// Strap pin positions
	// ---------------------------------------------------------------
	localparam int unsigned PUS_GPIO_W        = 6;
	localparam int unsigned PUS_STRAP_CLK_LO  = 0;
	localparam int unsigned PUS_STRAP_CLK_HI  = 1;
	localparam int unsigned PUS_STRAP_DIFF    = 2;

	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		PUS_MCLK_NONE,
		PUS_MCLK_20M,
		PUS_MCLK_24M576,
		PUS_MCLK_RESERVED
	} pus_mclk_t;

	typedef enum logic [1:0] {
		PUS_ST_HOLD,
		PUS_ST_STRAP,
		PUS_ST_RUN
	} pus_fsm_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} pus_req_t;

	typedef struct packed {
		pus_fsm_t               state;
		logic [PUS_CNT_W-1:0]   count;
		logic [5:0]             straps;
		pus_mclk_t              mclk_sel;
		logic                   strap_done;
		logic                   cfg_loaded;
		logic [7:0]             ref_mode;
		logic [7:0]             diff_en_sw;
		logic [3:0]             se_en_sw;
		logic [7:0]             diff_en;
		logic [3:0]             se_en;
		logic [7:0]             rdata;
		logic [5:0]             gpio;
	} pus_state_t;

	localparam pus_state_t PUS_STATE_RESET = '{
		state:      PUS_ST_HOLD,
		count:      '0,
		straps:     6'h00,
		mclk_sel:   PUS_MCLK_NONE,
		strap_done: 1'b0,
		cfg_loaded: 1'b0,
		ref_mode:   PUS_REF_MODE_RESET,
		diff_en_sw: PUS_DIFF_EN_RESET,
		se_en_sw:   PUS_SE_EN_RESET,
		diff_en:    PUS_DIFF_EN_RESET,
		se_en:      PUS_SE_EN_RESET,
		rdata:      8'h00,
		gpio:       6'h00
	};

endpackage

// >>> pus_sync.sv
`timescale 1ns/100ps
`default_nettype none

module pus_sync #(
	parameter int unsigned WIDTH = 1
) (
	input  wire logic             mclk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} pus_sync_state_t;

	pus_sync_state_t s_reg;
	pus_sync_state_t s_next;

	always_comb begin
		s_next.meta   = async_in;
		s_next.stable = s_reg.meta;
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign sync_out = s_reg.stable;

endmodule // pus_sync

`default_nettype wire

// >>> pus_tb.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import pus_pkg::*;
	logic       mclk = 0, reset = 1, restart = 1, power_reset_n, strap_done, cfg_loaded;
	logic [5:0] strap_cfg = 6'h00, gpio_pin, strap_value, gpio_in;
	logic [7:0] reg_rdata, ref_mode, diff_out_enable;
	logic [3:0] se_out_enable;
	pus_req_t   reg_req = '0;
	pus_mclk_t  mclk_sel;
	int         fails = 0, n_tests = 0;
	always #10 mclk = ~mclk;
	pus_board board_u (.mclk, .restart, .strap_cfg, .power_reset_n, .gpio_pin);
	pus_top #(.STRAP_CYCLES(20)) dut_u (.mclk, .reset, .power_reset_n, .gpio_pin, .reg_req,
		.reg_rdata, .mclk_sel, .strap_done, .cfg_loaded, .strap_value, .gpio_in,
		.ref_mode, .diff_out_enable, .se_out_enable);
	task automatic conclude();
		if (fails == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] addr, input logic [7:0] data);
		@(posedge mclk) reg_req <= '{wr, !wr, addr, data};
		@(posedge mclk) reg_req <= '0;
		#1;
	endtask
	function automatic pus_mclk_t exp_mclk(input logic [1:0] sel);
		case (sel)
			2'b10:   return PUS_MCLK_20M;
			2'b11:   return PUS_MCLK_24M576;
			default: return PUS_MCLK_RESERVED;
		endcase
	endfunction
	task automatic t_straps(input logic [5:0] cfg);
		@(posedge mclk);
		restart <= 1;
		strap_cfg <= cfg;
		@(posedge mclk);
		restart <= 0;
		for (int n = 0; n < 99 && cfg_loaded !== 1'b1; n++) @(posedge mclk) #1;
		chk({7'h00, cfg_loaded}, 8'h01);
		chk(ref_mode, PUS_REF_MODE_RESET);
		chk(diff_out_enable, 8'h00);
		chk({4'h0, se_out_enable}, 8'h00);
		bus(1, PUS_SE_EN_ADDR, 8'h0f);
		chk({4'h0, se_out_enable}, 8'h00);
		for (int n = 0; n < 99 && strap_done !== 1'b1; n++) @(posedge mclk) #1;
		chk({7'h00, strap_done}, 8'h01);
		chk(mclk_sel, exp_mclk(cfg[1:0]));
		chk(diff_out_enable, {7'h00, cfg[2]});
		repeat (30) @(posedge mclk);
		#1;
		chk({2'h0, strap_value}, {2'h0, cfg});
		chk({2'h0, gpio_in}, {2'h0, ~cfg});
	endtask
	task automatic t_regs(input logic [5:0] cfg);
		bus(1, PUS_REF_MODE_ADDR, 8'h0e);
		chk(ref_mode, 8'h0e);
		bus(0, PUS_REF_MODE_ADDR, 8'h00);
		chk(reg_rdata, 8'h0e);
		bus(1, PUS_DIFF_EN_ADDR, 8'h04);
		chk(diff_out_enable, {7'h02, cfg[2]});
		bus(0, PUS_DIFF_EN_ADDR, 8'h00);
		chk(reg_rdata, 8'h04);
		bus(1, PUS_SE_EN_ADDR, 8'h0a);
		chk({4'h0, se_out_enable}, 8'h0a);
		bus(0, PUS_STATUS_ADDR, 8'h00);
		chk(reg_rdata, {3'b000, 1'b1, cfg[2], 1'b0, exp_mclk(cfg[1:0])});
		bus(0, 8'hff, 8'h00);
		chk(reg_rdata, 8'h00);
	endtask
	initial begin
		repeat (5) @(posedge mclk);
		reset <= 0;
		restart <= 0;
		for (int i = 0; i < 4; i++) begin
			t_straps({3'b101, i[0], i[1:0]});
			t_regs({3'b101, i[0], i[1:0]});
		end
		conclude();
	end
	initial begin
		#100000;
		fails++;
		conclude();
	end
endmodule // testbench
`default_nettype wire

// >>> pus_top.sv
// How it works
// - Clock straps 10=20MHz, 11=24.576MHz, else reserved
// - After 55 ms clock straps become GPIO
// - Reset end loads all default settings
// - Straps sampled from pins held 55 ms
// - All outputs but diff output zero disabled until software enables
// - Diff strap high enables diff output zero
// - Ref0 differential, others single ended, at 0x0A
`timescale 1ns/100ps
`default_nettype none

module pus_top
	import pus_pkg::*;
#(
	parameter int unsigned STRAP_CYCLES = PUS_STRAP_CYCLES
) (
	input  wire logic                  mclk,
	input  wire logic                  reset,
	input  wire logic                  power_reset_n,
	input  wire logic [PUS_GPIO_W-1:0] gpio_pin,
	input  wire pus_req_t              reg_req,
	output logic      [7:0]            reg_rdata,
	output pus_mclk_t                  mclk_sel,
	output logic                       strap_done,
	output logic                       cfg_loaded,
	output logic      [5:0]            strap_value,
	output logic      [PUS_GPIO_W-1:0] gpio_in,
	output logic      [7:0]            ref_mode,
	output logic      [7:0]            diff_out_enable,
	output logic      [3:0]            se_out_enable
);

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	logic                  pwr_ok;
	logic [PUS_GPIO_W-1:0] gpio_sync;

	pus_sync #(
		.WIDTH (1)
	) u_pwr_sync (
		.mclk     (mclk),
		.reset    (reset),
		.async_in (power_reset_n),
		.sync_out (pwr_ok)
	);

	pus_sync #(
		.WIDTH (PUS_GPIO_W)
	) u_gpio_sync (
		.mclk     (mclk),
		.reset    (reset),
		.async_in (gpio_pin),
		.sync_out (gpio_sync)
	);

	// ---------------------------------------------------------------
	// Strap decode
	// ---------------------------------------------------------------
	function automatic pus_mclk_t decode_mclk(input logic [1:0] sel);
		case (sel)
			2'b10:   decode_mclk = PUS_MCLK_20M;
			2'b11:   decode_mclk = PUS_MCLK_24M576;
			default: decode_mclk = PUS_MCLK_RESERVED;
		endcase
	endfunction

	localparam logic [PUS_CNT_W-1:0] STRAP_LAST = PUS_CNT_W'(STRAP_CYCLES - 1);

	// ---------------------------------------------------------------
	// Strap latch
	// ---------------------------------------------------------------
	// One sample of every strap, held until the next reset
	function automatic pus_state_t latch_straps(
		input pus_state_t            cur,
		input logic [PUS_GPIO_W-1:0] pins
	);
		pus_state_t upd;
		upd            = cur;
		upd.straps     = pins;
		upd.mclk_sel   = decode_mclk(
			{pins[PUS_STRAP_CLK_HI], pins[PUS_STRAP_CLK_LO]});
		upd.strap_done = 1'b1;
		upd.state      = PUS_ST_RUN;
		return upd;
	endfunction

	// ---------------------------------------------------------------
	// Write port
	// ---------------------------------------------------------------
	// Only called once the straps are latched; earlier writes are dropped
	function automatic pus_state_t apply_write(
		input pus_state_t cur,
		input pus_req_t   req
	);
		pus_state_t upd;
		upd = cur;
		if (req.wr) begin
			case (req.addr)
				PUS_REF_MODE_ADDR: upd.ref_mode   = req.wdata;
				PUS_DIFF_EN_ADDR:  upd.diff_en_sw = req.wdata;
				PUS_SE_EN_ADDR:    upd.se_en_sw   = req.wdata[3:0];
				default:           upd.ref_mode   = cur.ref_mode;
			endcase
		end
		return upd;
	endfunction

	// ---------------------------------------------------------------
	// Read port
	// ---------------------------------------------------------------
	// Status word packs the strap results, unmapped addresses read zero
	function automatic logic [7:0] read_word(
		input pus_state_t cur,
		input logic [7:0] addr
	);
		logic [7:0] word;
		case (addr)
			PUS_REF_MODE_ADDR: word = cur.ref_mode;
			PUS_DIFF_EN_ADDR:  word = cur.diff_en_sw;
			PUS_SE_EN_ADDR:    word = {4'h0, cur.se_en_sw};
			PUS_STATUS_ADDR:   word = {3'b000, cur.strap_done,
				cur.straps[PUS_STRAP_DIFF], 1'b0, cur.mclk_sel};
			default:           word = 8'h00;
		endcase
		return word;
	endfunction

	// ---------------------------------------------------------------
	// Output enables
	// ---------------------------------------------------------------
	// Software bits, with the diff strap also forcing output zero on
	function automatic logic [7:0] diff_enables(input pus_state_t cur);
		logic [7:0] en;
		en    = cur.diff_en_sw;
		en[0] = cur.diff_en_sw[0] | (cur.strap_done & cur.straps[PUS_STRAP_DIFF]);
		return en;
	endfunction

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	pus_state_t s_reg;
	pus_state_t s_next;

	always_comb begin
		s_next            = s_reg;
		s_next.cfg_loaded = 1'b0;
		s_next.gpio       = gpio_sync;

		// -----------------------------------------------------------
		// Power-up sequence
		// -----------------------------------------------------------
		if (!pwr_ok) begin
			// Held in reset while the power pin is low
			s_next = PUS_STATE_RESET;
		end else begin
			case (s_reg.state)
				PUS_ST_HOLD: begin
					s_next.state      = PUS_ST_STRAP;
					s_next.count      = '0;
					s_next.cfg_loaded = 1'b1;
				end
				PUS_ST_STRAP: begin
					// Pins seen through the synchroniser, two cycles late
					if (s_reg.count == STRAP_LAST) begin
						s_next = latch_straps(s_next, gpio_sync);
					end else begin
						s_next.count = s_reg.count + 1'b1;
					end
				end
				PUS_ST_RUN: begin
					// Only state that takes register writes
					s_next = apply_write(s_next, reg_req);
				end
				default: begin
					s_next.state = PUS_ST_HOLD;
				end
			endcase
		end

		// -----------------------------------------------------------
		// Output enables
		// -----------------------------------------------------------
		s_next.diff_en = diff_enables(s_next);
		s_next.se_en   = s_next.se_en_sw;

		// -----------------------------------------------------------
		// Read data
		// -----------------------------------------------------------
		s_next.rdata = 8'h00;
		if (reg_req.rd) begin
			s_next.rdata = read_word(s_reg, reg_req.addr);
		end

		// -----------------------------------------------------------
		// Synchronous reset wins over everything
		// -----------------------------------------------------------
		if (reset) begin
			s_next = PUS_STATE_RESET;
		end
	end

	always_ff @(posedge mclk) begin
		s_reg <= s_next;
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign reg_rdata       = s_reg.rdata;
	assign mclk_sel        = s_reg.mclk_sel;
	assign strap_done      = s_reg.strap_done;
	assign cfg_loaded      = s_reg.cfg_loaded;
	assign strap_value     = s_reg.straps;
	assign gpio_in         = s_reg.gpio;
	assign ref_mode        = s_reg.ref_mode;
	assign diff_out_enable = s_reg.diff_en;
	assign se_out_enable   = s_reg.se_en;

endmodule // pus_top

`default_nettype wire
